//--- sadc_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the successive-approximation converter sequencer.
// Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ************************************
// Register map (byte addresses)
// ************************************
`define SADC_OFS_MODE 8'h00
`define SADC_OFS_RESULT 8'h04
`define SADC_OFS_EDGE 8'h08
`define SADC_OFS_STATUS 8'h0c

// ************************************
// Mode register fields
// ************************************
`define SADC_MODE_SEL_BIT 0
`define SADC_CHAN_LSB 1
`define SADC_CHAN_MSB 3
`define SADC_FAST_BIT 4
`define SADC_SCAN_VAR_BIT 5
`define SADC_SYNC_BIT 6
`define SADC_RUN_BIT 7
`define SADC_MODE_RESET 8'h00
`define SADC_EDGE_RESET 8'h01

// ************************************
// Timing
// ************************************
`define SADC_CLK_MHZ 50
`define SADC_SAMPLE_NS 1920
`define SADC_STEP_NS 960
// Least times, rounded up to whole clock cycles
`define SADC_SAMPLE_CYC ((`SADC_SAMPLE_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_STEP_CYC ((`SADC_STEP_NS * `SADC_CLK_MHZ + 999) / 1000)

`endif

//--- sadc_front.sv
// Behavioural analog side: eight input levels and a comparator.
// Assumes input k sits at vin_in[8k+7:8k]; sequencer drives tap and channel.
`timescale 1ns/10ps
module sadc_front (
    input wire logic ref_clk_in,
    input wire logic [63:0] vin_in,
    input wire logic [2:0] channel_in,
    input wire logic [7:0] tap_code_in,
    input wire logic power_down_in,
    output logic comp_out
);
    logic junk_q = 1'b0;
    // Unpowered comparator gives no steady level, so it wanders
    always_ff @(posedge ref_clk_in) begin
        junk_q <= !junk_q;
    end
    assign comp_out = power_down_in ? junk_q : (vin_in[{channel_in, 3'h0} +: 8] >= tap_code_in);
endmodule

//--- sadc_pkg.sv
// Types shared by the converter sequencer.
// Assumes sadc_defs.svh supplies the numeric constants.
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SAMPLE,
        SADC_STEP
    } sadc_state_e;
endpackage

//--- sadc_seq.sv
// Sequencer for an 8-bit successive-approximation converter, eight inputs.
// Assumes an analog front end (tap selector, comparator, sample and hold)
// outside, and an AHB-Lite master for the registers.
// Timing assumes the comparator settles well inside one bit step.
//
// Summary of operation
// RULE1: Eight inputs multiplexed, channel from mode register.
// RULE2: Approximation register decides bits MSB to LSB.
// RULE3: After LSB, copy approximation into result.
// RULE4: Done interrupt on every result transfer.
// RULE5: Result register has no reset value.
// RULE6: Trigger pin edge, selectable polarity, raises request.
// RULE7: Sync and run set: edge restarts sequence.
// RULE8: Sync clear: trigger pin ignored.
// RULE9: Writing run bit one starts conversion.
// RULE10: Clearing run aborts, no result, no interrupt.
// RULE11: Run clear powers down the comparator.
// RULE12: Reset clears mode register to zero.
// RULE13: Bit 0 chooses scan or select mode.
// RULE14: Bits 1 to 3 select channel field.
// RULE15: Bit 5 chooses scan variant.
// RULE16: Low-power state halts, comparator power follows run.
// RULE17: Conversions repeat back to back while running.
// RULE18: Software writes mode, clears flag, then masks.
// RULE19: Variant 0: clear flag within one conversion.
// RULE20: Alternatively stop, clear flag, mask, then write.
// RULE21: Scan mode converts selected inputs in order.
// RULE22: Select mode repeats one chosen input.
// RULE23: Variant 0 scans inputs 0 up to field.
// RULE24: Variant 1: unread result restarts, nothing updated.
// RULE25: Any mode write restarts the conversion.
// RULE26: Trial code to taps, comparator sampled at step end.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps

`include "sadc_defs.svh"

module sadc_seq
    import sadc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Analog front end and pins
    input wire logic comp_in,
    input wire logic ext_trigger_pin_in,
    input wire logic low_power_in,
    output logic [2:0] channel_out,
    output logic [7:0] tap_code_out,
    output logic sample_out,
    output logic comp_power_down_out,
    output logic conversion_done_irq_out,
    output logic ext_trigger_irq_out
);

    // ************************************
    // Declarations
    // ************************************
    logic [7:0] converter_mode_reg_q;
    logic [7:0] result_reg_q;
    logic edge_rising_q;
    logic unread_q;
    logic [7:0] approx_reg_q;
    logic [2:0] bit_q;
    logic [2:0] chan_q;
    logic [7:0] cyc_q;
    sadc_state_e state_q;
    logic [31:0] hrdata_q;
    logic done_q;
    logic trig_irq_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic comp_s1_q;
    logic comp_s2_q;
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic lp_s1_q;
    logic lp_s2_q;

    // ************************************
    // Bus decode
    // ************************************
    wire addr_ok = hsel_in && hready_in && htrans_in[1];
    wire rd_acc = addr_ok && !hwrite_in;
    wire wr_acc = addr_ok && hwrite_in;
    wire mode_wr = wr_pend_q && (wr_addr_q == `SADC_OFS_MODE);
    wire edge_wr = wr_pend_q && (wr_addr_q == `SADC_OFS_EDGE);
    wire result_rd = rd_acc && (haddr_in == `SADC_OFS_RESULT);
    wire [7:0] mode_d = hwdata_in[7:0];

    // Mode register fields
    wire run_bit = converter_mode_reg_q[`SADC_RUN_BIT];
    wire sync_bit = converter_mode_reg_q[`SADC_SYNC_BIT];
    wire scan_mode = converter_mode_reg_q[`SADC_MODE_SEL_BIT];
    // RULE15: scan variant bit
    wire scan_var1 = converter_mode_reg_q[`SADC_SCAN_VAR_BIT];
    wire fast_bit = converter_mode_reg_q[`SADC_FAST_BIT];
    wire [2:0] chan_field = converter_mode_reg_q[`SADC_CHAN_MSB:`SADC_CHAN_LSB];

    // ************************************
    // Helper functions
    // ************************************
    // First channel of a sequence: scan always opens at input 0
    function automatic logic [2:0] first_chan(input logic [7:0] mode);
        logic [2:0] first;
        first = mode[`SADC_CHAN_MSB:`SADC_CHAN_LSB];
        if (mode[`SADC_MODE_SEL_BIT]) begin
            first = 3'h0;
        end
        return first;
    endfunction

    // Phase length in clocks; the slow setting doubles every phase
    function automatic logic [7:0] phase_len(input logic fast, input logic [7:0] base);
        logic [7:0] len;
        len = fast ? base : {base[6:0], 1'b0};
        return len;
    endfunction

    // Status word: busy and unread let software poll instead of taking the request
    wire busy = (state_q != SADC_IDLE);
    wire chan_low_nz = (chan_q[1:0] != 2'h0);
    wire [31:0] status_word = {28'h0000000, unread_q, busy, chan_low_nz, run_bit};

    // Read multiplexer, unmapped addresses read as zero
    wire [31:0] rd_mux =
        (haddr_in == `SADC_OFS_MODE) ? {24'h000000, converter_mode_reg_q} :
        (haddr_in == `SADC_OFS_RESULT) ? {24'h000000, result_reg_q} :
        (haddr_in == `SADC_OFS_EDGE) ? {31'h00000000, edge_rising_q} :
        (haddr_in == `SADC_OFS_STATUS) ? status_word :
        32'h00000000;

    // Zero wait states, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;

    // ************************************
    // Synchronisers and edge detection
    // ************************************
    // Limitation: the comparator level must stand two clocks before a step
    // ends; the shortest step leaves ample margin for that
    // Comparator, trigger pin and low-power request all arrive asynchronously
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            lp_s1_q <= 1'b0;
            lp_s2_q <= 1'b0;
        end else begin
            comp_s1_q <= comp_in;
            comp_s2_q <= comp_s1_q;
            trig_s1_q <= ext_trigger_pin_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            lp_s1_q <= low_power_in;
            lp_s2_q <= lp_s1_q;
        end
    end

    // Third stage feeds only the edge detector, never other logic
    // RULE6: edge with polarity
    wire trig_edge = edge_rising_q ? (trig_s2_q && !trig_s3_q) : (!trig_s2_q && trig_s3_q);
    // RULE7: sync restart
    // RULE8: pin ignored without sync
    wire trig_restart = trig_edge && sync_bit && run_bit;

    // ************************************
    // Sequencing decisions
    // ************************************
    // Eight bits cover the longest phase, slow sampling at twice the sample count
    wire [7:0] step_len = phase_len(fast_bit, 8'(`SADC_STEP_CYC));
    wire [7:0] samp_len = phase_len(fast_bit, 8'(`SADC_SAMPLE_CYC));
    wire last_cyc = (state_q == SADC_SAMPLE) ? (cyc_q == samp_len - 8'h01) :
                    (cyc_q == step_len - 8'h01);
    wire conv_end = (state_q == SADC_STEP) && last_cyc && (bit_q == 3'h0);
    // RULE24: unread result discards this conversion
    // Discarded runs keep the channel and skip result and request
    wire discard = scan_mode && scan_var1 && unread_q;
    wire deliver = conv_end && !discard;
    // RULE21: scan in order
    // RULE23: inputs 0 up to field
    // Scan wraps to input 0 after the field value
    wire [2:0] scan_next = (chan_q >= chan_field) ? 3'h0 : chan_q + 3'h1;
    // RULE13: scan or select
    // RULE22: select repeats one
    wire [2:0] next_chan = scan_mode ? scan_next : chan_field;
    // RULE25: write restarts
    wire restart = mode_wr || trig_restart;
    wire [2:0] new_first = first_chan(mode_d);
    wire [2:0] trig_first = first_chan(converter_mode_reg_q);
    wire halted = lp_s2_q;
    // One qualifier for result, request and unread flag, so the three stay
    // together when an abort, restart or low-power entry meets the last step
    wire xfer = deliver && !restart && run_bit && !halted;

    // ************************************
    // Register bus
    // ************************************
    // Write data arrives one cycle after its address phase
    // Address captured every cycle; only wr_pend_q qualifies it
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= wr_acc;
            wr_addr_q <= haddr_in;
            if (rd_acc) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Mode and edge registers
    // Edge polarity: 1 selects rising, 0 falling
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            // RULE12: mode cleared
            converter_mode_reg_q <= `SADC_MODE_RESET;
            edge_rising_q <= 1'b1;
        end else begin
            if (mode_wr) begin
                converter_mode_reg_q <= mode_d;
            end
            if (edge_wr) begin
                edge_rising_q <= hwdata_in[0];
            end
        end
    end

    // Unread tracker; a new result beats a read in the same cycle
    // Mode writes clear it too, so a fresh setup never opens by discarding
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unread_q <= 1'b0;
        end else if (xfer) begin
            unread_q <= 1'b1;
        end else if (result_rd || mode_wr) begin
            unread_q <= 1'b0;
        end
    end

    // ************************************
    // Conversion state machine
    // ************************************
    // Conversion state; restarts and aborts override any step in flight
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SADC_IDLE;
            cyc_q <= 8'h00;
            bit_q <= 3'h7;
            chan_q <= 3'h0;
        end else if (mode_wr) begin
            // RULE9: run starts
            // RULE10: run clear aborts
            state_q <= mode_d[`SADC_RUN_BIT] ? SADC_SAMPLE : SADC_IDLE;
            cyc_q <= 8'h00;
            bit_q <= 3'h7;
            // RULE1: channel from field
            // RULE14: channel field
            chan_q <= new_first;
        end else if (!run_bit) begin
            // Stopped: hold idle until the next mode write
            state_q <= SADC_IDLE;
            cyc_q <= 8'h00;
        end else if (trig_restart) begin
            state_q <= SADC_SAMPLE;
            cyc_q <= 8'h00;
            bit_q <= 3'h7;
            chan_q <= trig_first;
        end else if (halted) begin
            // RULE16: halted while low power
            state_q <= SADC_IDLE;
            cyc_q <= 8'h00;
        end else begin
            unique case (state_q)
                SADC_IDLE: begin
                    // Resume after low power from a fresh sample
                    state_q <= SADC_SAMPLE;
                    cyc_q <= 8'h00;
                    bit_q <= 3'h7;
                end
                SADC_SAMPLE: begin
                    // Sample phase, then the MSB step
                    cyc_q <= last_cyc ? 8'h00 : cyc_q + 8'h01;
                    if (last_cyc) begin
                        state_q <= SADC_STEP;
                        bit_q <= 3'h7;
                    end
                end
                SADC_STEP: begin
                    // One bit per step, MSB first
                    cyc_q <= last_cyc ? 8'h00 : cyc_q + 8'h01;
                    if (conv_end) begin
                        // RULE17: next conversion at once
                        state_q <= SADC_SAMPLE;
                        if (xfer) begin
                            chan_q <= next_chan;
                        end
                    end else if (last_cyc) begin
                        bit_q <= bit_q - 3'h1;
                    end
                end
            endcase
        end
    end

    // Approximation register: trial bit set when its step begins
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            approx_reg_q <= 8'h00;
        end else if (restart || state_q != SADC_STEP) begin
            approx_reg_q <= 8'h80;
        end else if (last_cyc) begin
            // RULE2: decide one bit
            // RULE26: comparator sampled at step end
            approx_reg_q[bit_q] <= comp_s2_q;
            // Bit zero has no lower trial bit to seed
            if (bit_q != 3'h0) begin
                approx_reg_q[bit_q - 3'h1] <= 1'b1;
            end
        end
    end

    // Result has no reset, so the flop carries none
    always_ff @(posedge ref_clk_in) begin
        // RULE3: copy on completion
        // RULE5: no reset value
        if (xfer) begin
            result_reg_q <= {approx_reg_q[7:1], comp_s2_q};
        end
    end

    // ************************************
    // Event pulses
    // ************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_q <= 1'b0;
            trig_irq_q <= 1'b0;
        end else begin
            // RULE4: done pulse with transfer
            done_q <= xfer;
            // Trigger request on every valid edge, whatever the sync bit
            trig_irq_q <= trig_edge;
        end
    end

    // ************************************
    // Front-end outputs
    // ************************************
    assign conversion_done_irq_out = done_q;
    assign ext_trigger_irq_out = trig_irq_q;
    // Channel and tap move only on clock edges, so the analog side sees clean steps
    assign tap_code_out = approx_reg_q;
    assign channel_out = chan_q;
    assign sample_out = (state_q == SADC_SAMPLE);
    // RULE11: power down when stopped
    // RULE16: low power keeps comparator on
    assign comp_power_down_out = !run_bit;

endmodule

//--- sadc_seq_assertions.sv
// Concurrent checks on the converter sequencer ports.
// Assumes it is bound into sadc_seq and sees only that module's ports.
`timescale 1ns/10ps
module sadc_seq_assertions (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic low_power_in,
    input wire logic sample_out,
    input wire logic comp_power_down_out,
    input wire logic conversion_done_irq_out,
    input wire logic ext_trigger_irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ************************************
    // Properties
    // ************************************
    property p_done_pulse;
        conversion_done_irq_out |=> !conversion_done_irq_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done request wider than one cycle");
    property p_trig_pulse;
        ext_trigger_irq_out |=> !ext_trigger_irq_out;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("trigger request wider than one cycle");
    property p_done_powered;
        conversion_done_irq_out |-> !comp_power_down_out;
    endproperty
    a_done_powered: assert property (p_done_powered)
        else $error("result delivered while stopped");
    // Two cycles of stop so the abort edge itself is allowed to settle
    property p_quiet;
        $past(comp_power_down_out) && comp_power_down_out |-> !sample_out && !conversion_done_irq_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("activity while comparator unpowered");
    property p_restart;
        conversion_done_irq_out && !low_power_in |-> ##[0:2] sample_out;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no new conversion after done");
    property p_steps;
        conversion_done_irq_out |-> !$past(sample_out, 8);
    endproperty
    a_steps: assert property (p_steps)
        else $error("done too soon after sampling");
    property p_reset_power;
        $fell(rst_in) |-> comp_power_down_out;
    endproperty
    a_reset_power: assert property (p_reset_power)
        else $error("comparator powered after reset");
    property p_start_powered;
        $rose(sample_out) |-> !comp_power_down_out;
    endproperty
    a_start_powered: assert property (p_start_powered)
        else $error("sampling with comparator unpowered");
endmodule

bind sadc_seq sadc_seq_assertions u_chk (.*);

//--- sadc_seq_bench.sv
// Self-checking bench for the converter sequencer.
// Assumes sadc_front as analog side and this bench as the only bus master.
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_seq_bench
    import sadc_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic ext = 1'b0;
    logic lowp = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r;
    logic hrdy, hresp, comp, samp, pdn, done, xirq;
    logic [2:0] chan, ch;
    logic [7:0] tap;
    logic [63:0] vin = 64'h0;
    logic [2:0] q[$];
    int n_fail = 0;
    int total_checks = 0;
    int n_ext = 0;
    int seed, last, n0;

    always #10 ref_clk_in = !ref_clk_in;

    sadc_seq dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hrdy),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .comp_in(comp), .ext_trigger_pin_in(ext), .low_power_in(lowp), .channel_out(chan),
        .tap_code_out(tap), .sample_out(samp), .comp_power_down_out(pdn),
        .conversion_done_irq_out(done), .ext_trigger_irq_out(xirq));
    sadc_front front (.ref_clk_in(ref_clk_in), .vin_in(vin), .channel_in(chan),
        .tap_code_in(tap), .power_down_in(pdn), .comp_out(comp));

    // ************************************
    // Helpers
    // ************************************
    task automatic end_sim;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic void chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            n_fail++;
        end
    endfunction
    // Single word transfer; request held until hready seen high
    // Select stays high between calls; IDLE htrans marks the gap
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge ref_clk_in); k++; end while (hrdy !== 1'b1 && k < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge ref_clk_in); k++; end while (hrdy !== 1'b1 && k < 40);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
        if (k >= 40) begin n_fail++; end_sim; end
    endtask
    task automatic exp_ch(input int c);
        q.push_back(c[2:0]);
        last = c;
    endtask
    task automatic drain(input bit rd);
        int k;
        k = 0;
        while (q.size() != 0 && k < 4000) begin @(posedge ref_clk_in); k++; end
        if (k >= 4000) begin n_fail++; end_sim; end
        if (rd) begin
            bus(`SADC_OFS_RESULT, 1'b0, 32'h0);
            chk(r, {24'h0, vin[last*8 +: 8]});
        end
    endtask
    // Pin pulse; one request, on the rise or the fall as polarity says
    task automatic trig(input int rise);
        n0 = n_ext;
        ext <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        chk(n_ext, n0 + rise);
        ext <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        chk(n_ext, n0 + 1);
    endtask
    // stop before a new mode
    // Stop, then a quiet spell in which any done is flagged by the monitor
    task automatic stop(input string s);
        bus(`SADC_OFS_MODE, 1'b1, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        chk({31'h0, pdn}, 32'h1);
        repeat (500) @(posedge ref_clk_in);
        $display("test %s done", s);
    endtask

    // request taken within one conversion
    // Each finished conversion against the oldest expected channel
    always @(posedge ref_clk_in) begin
        if (samp === 1'b1) ch <= chan;
        if (xirq === 1'b1) n_ext++;
        if (done === 1'b1) begin
            if (q.size() == 0) chk(32'h1, 32'h0);
            else chk({29'h0, ch}, {29'h0, q.pop_front()});
        end
    end

    // ************************************
    // Scenarios, fast timing (bit 4) except the last
    // ************************************
    initial begin
        seed = 32'h8dbb;
        vin = {$random(seed), $random(seed)};
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        bus(`SADC_OFS_MODE, 1'b0, 32'h0);
        chk(r, {24'h0, `SADC_MODE_RESET});
        bus(`SADC_OFS_EDGE, 1'b0, 32'h0);
        chk(r, {24'h0, `SADC_EDGE_RESET});
        bus(8'h10, 1'b1, 32'hff);
        bus(8'h10, 1'b0, 32'h0);
        chk(r, 32'h0);
        $display("test reset done");
        exp_ch(5);
        exp_ch(5);
        bus(`SADC_OFS_MODE, 1'b1, 32'h9a);
        drain(1'b1);
        stop("select");
        for (int i = 0; i < 4; i++) exp_ch(i % 3);
        bus(`SADC_OFS_MODE, 1'b1, 32'h95);
        // Edge during the input 1 conversion: a restart would break the order
        repeat (600) @(posedge ref_clk_in);
        trig(1);
        drain(1'b1);
        stop("scan");
        bus(`SADC_OFS_MODE, 1'b1, 32'h9a);
        repeat (200) @(posedge ref_clk_in);
        exp_ch(6);
        bus(`SADC_OFS_MODE, 1'b1, 32'h9c);
        drain(1'b1);
        stop("rewrite");
        exp_ch(0);
        bus(`SADC_OFS_MODE, 1'b1, 32'hd5);
        drain(1'b0);
        repeat (100) @(posedge ref_clk_in);
        trig(1);
        exp_ch(0);
        drain(1'b1);
        stop("sync");
        bus(`SADC_OFS_MODE, 1'b1, 32'h9a);
        repeat (100) @(posedge ref_clk_in);
        lowp <= 1'b1;
        repeat (600) @(posedge ref_clk_in);
        chk({31'h0, pdn}, 32'h0);
        exp_ch(5);
        lowp <= 1'b0;
        drain(1'b1);
        stop("lowpower");
        exp_ch(0);
        bus(`SADC_OFS_MODE, 1'b1, 32'hb3);
        drain(1'b0);
        repeat (1000) @(posedge ref_clk_in);
        bus(`SADC_OFS_RESULT, 1'b0, 32'h0);
        chk(r, {24'h0, vin[7:0]});
        exp_ch(1);
        drain(1'b1);
        stop("variant1");
        bus(`SADC_OFS_EDGE, 1'b1, 32'h0);
        trig(0);
        exp_ch(5);
        bus(`SADC_OFS_MODE, 1'b1, 32'h8a);
        drain(1'b1);
        stop("slow");
        end_sim();
    end
endmodule
